// file: e1tx_map.svh
// Timing constants for the E1 transmit input encoder and its terminal end
`ifndef E1TX_MAP_SVH
`define E1TX_MAP_SVH

// System clock period in ns (20 MHz)
`define E1TX_CLK_NS 50
// One bit period at 2.048 Mbit/s in ns
`define E1TX_BIT_NS 488
// Line mark width limits in ns
`define E1TX_MARK_MIN_NS 224
`define E1TX_MARK_MAX_NS 264
// Link clock silence that ends clocked mode, in ns
`define E1TX_ACT_NS 2000

`endif

// file: e1tx_pkg.sv
// Types shared by both ends of the E1 transmit input link
`default_nettype none

package e1tx_pkg;

  typedef enum logic {
    MODE_CLOCKLESS,
    MODE_CLOCKED
  } e1tx_mode_t;

  typedef enum logic [1:0] {
    LINE_IDLE,
    LINE_POS,
    LINE_NEG
  } e1tx_line_t;

endpackage

`default_nettype wire

// file: e1tx_if.sv
// Dual-rail link between terminal equipment and the transmit encoder
`timescale 1ns/1ps
`default_nettype none

interface e1tx_if;
  logic sendBitClock;
  logic sendPositiveMark;
  logic sendNegativeMark;

  modport device (
    input sendBitClock,
    input sendPositiveMark,
    input sendNegativeMark
  );

  modport term (
    output sendBitClock,
    output sendPositiveMark,
    output sendNegativeMark
  );
endinterface

`default_nettype wire

// file: e1tx_term.sv
// Terminal end: drives dual-rail marks and the optional bit clock
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_map.svh"

module e1tx_term #(
  parameter int BIT_NS = `E1TX_BIT_NS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  e1tx_if.term link,
  input var e1tx_pkg::e1tx_mode_t sendMode,
  input wire logic bitValid,
  input wire logic bitPos,
  input wire logic bitNeg,
  output logic bitReady
);
  import e1tx_pkg::*;

  localparam int CLK_NS = `E1TX_CLK_NS;
  // Nearest whole cycle count to one bit period
  localparam int BIT_CYC = (BIT_NS + CLK_NS / 2) / CLK_NS;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int PW = $clog2(BIT_CYC);
  localparam logic [PW-1:0] LAST_PH = PW'(BIT_CYC - 1);
  localparam logic [PW-1:0] HALF_PH = PW'(HALF_CYC);

  logic [PW-1:0] phase_ff;
  logic [PW-1:0] nxt_phase;
  logic startBit;
  logic curPos_ff;
  logic curNeg_ff;
  logic nxt_curPos;
  logic nxt_curNeg;
  e1tx_mode_t mode_ff;
  e1tx_mode_t nxt_mode;
  logic firstHalf;
  logic bitClock_ff;
  logic posOut_ff;
  logic negOut_ff;
  logic bitReady_ff;

  always_comb begin
    nxt_phase = (phase_ff == LAST_PH) ? '0 : phase_ff + PW'(1);
    startBit = (nxt_phase == '0);
    firstHalf = (nxt_phase < HALF_PH);
    nxt_mode = startBit ? sendMode : mode_ff;
    // Positive rail wins; both rails never go high together
    nxt_curPos = startBit ? (bitValid & bitPos) : curPos_ff;
    nxt_curNeg = startBit ? (bitValid & bitNeg & ~bitPos) : curNeg_ff;
  end

  // Bit period timing, one bit every BIT_CYC cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= LAST_PH;
      mode_ff <= MODE_CLOCKLESS;
      curPos_ff <= 1'b0;
      curNeg_ff <= 1'b0;
      bitReady_ff <= 1'b0;
    end else if (ce) begin
      phase_ff <= nxt_phase;
      mode_ff <= nxt_mode;
      curPos_ff <= nxt_curPos;
      curNeg_ff <= nxt_curNeg;
      bitReady_ff <= startBit & bitValid;
    end
  end

  // Free-running divided clock in clocked mode, held high otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitClock_ff <= 1'b1;
    end else if (ce) begin
      if (nxt_mode == MODE_CLOCKED) begin
        bitClock_ff <= firstHalf;
      end else begin
        bitClock_ff <= 1'b1;
      end
    end
  end

  // NRZ for the whole bit, or RZ in the first half only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      posOut_ff <= 1'b0;
      negOut_ff <= 1'b0;
    end else if (ce) begin
      if (nxt_mode == MODE_CLOCKED) begin
        posOut_ff <= nxt_curPos;
        negOut_ff <= nxt_curNeg;
      end else begin
        posOut_ff <= nxt_curPos & firstHalf;
        negOut_ff <= nxt_curNeg & firstHalf;
      end
    end
  end

  assign link.sendBitClock = bitClock_ff;
  assign link.sendPositiveMark = posOut_ff;
  assign link.sendNegativeMark = negOut_ff;
  assign bitReady = bitReady_ff;

endmodule

`default_nettype wire

// file: e1tx_dev.sv
// Device end: samples dual-rail marks and drives bipolar line marks
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_map.svh"

module e1tx_dev #(
  parameter int ACT_NS = `E1TX_ACT_NS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  e1tx_if.device link,
  output logic lineDriveOutA,
  output logic lineDriveOutB,
  output var e1tx_pkg::e1tx_mode_t lineMode,
  output logic railClash
);
  import e1tx_pkg::*;

  localparam int CLK_NS = `E1TX_CLK_NS;
  // Least width rounds up, longest rounds down
  localparam int MARK_MIN_CYC = (`E1TX_MARK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MARK_MAX_CYC = `E1TX_MARK_MAX_NS / CLK_NS;
  localparam int MARK_CYC = (MARK_MIN_CYC < 1) ? 1 : MARK_MIN_CYC;
  localparam int ACT_CYC = (ACT_NS / CLK_NS < 1) ? 1 : ACT_NS / CLK_NS;
  localparam int MW = $clog2(MARK_CYC + 1);
  localparam int AW = $clog2(ACT_CYC + 1);
  localparam logic [MW-1:0] MARK_LAST = MW'(MARK_CYC - 1);
  localparam logic [AW-1:0] ACT_LIMIT = AW'(ACT_CYC);

  // Edge helpers shared by clock and rail detection
  function automatic logic isRise(input logic prev, input logic cur);
    isRise = ~prev & cur;
  endfunction

  function automatic logic isFall(input logic prev, input logic cur);
    isFall = prev & ~cur;
  endfunction

  // Two-stage synchronisers for the three link inputs
  logic clkSync1_ff;
  logic clkSync2_ff;
  logic clkPrev_ff;
  logic posSync1_ff;
  logic posSync2_ff;
  logic posPrev_ff;
  logic negSync1_ff;
  logic negSync2_ff;
  logic negPrev_ff;

  // Mode detection
  logic [AW-1:0] idleCnt_ff;
  logic [AW-1:0] nxt_idleCnt;
  e1tx_mode_t lineMode_ff;
  e1tx_mode_t nxt_lineMode;

  // Capture and line mark generation
  logic clockFall;
  logic clockEdge;
  logic takePos;
  logic takeNeg;
  e1tx_line_t lineState_ff;
  e1tx_line_t nxt_lineState;
  logic [MW-1:0] markCnt_ff;
  logic [MW-1:0] nxt_markCnt;
  logic driveA_ff;
  logic driveB_ff;
  logic railClash_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Link clock idles high, so no false edge follows reset
      clkSync1_ff <= 1'b1;
      clkSync2_ff <= 1'b1;
      posSync1_ff <= 1'b0;
      posSync2_ff <= 1'b0;
      negSync1_ff <= 1'b0;
      negSync2_ff <= 1'b0;
    end else if (ce) begin
      clkSync1_ff <= link.sendBitClock;
      clkSync2_ff <= clkSync1_ff;
      posSync1_ff <= link.sendPositiveMark;
      posSync2_ff <= posSync1_ff;
      negSync1_ff <= link.sendNegativeMark;
      negSync2_ff <= negSync1_ff;
    end
  end

  // Previous synchronised values for edge finding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkPrev_ff <= 1'b1;
      posPrev_ff <= 1'b0;
      negPrev_ff <= 1'b0;
    end else if (ce) begin
      clkPrev_ff <= clkSync2_ff;
      posPrev_ff <= posSync2_ff;
      negPrev_ff <= negSync2_ff;
    end
  end

  always_comb begin
    clockFall = isFall(clkPrev_ff, clkSync2_ff);
    clockEdge = clockFall | isRise(clkPrev_ff, clkSync2_ff);
  end

  // Cycles since the last clock edge, saturating at the limit
  always_comb begin
    if (clockEdge) begin
      nxt_idleCnt = '0;
    end else if (idleCnt_ff < ACT_LIMIT) begin
      nxt_idleCnt = idleCnt_ff + AW'(1);
    end else begin
      nxt_idleCnt = idleCnt_ff;
    end
    // Activity means clocked, silence means clockless
    if (clockEdge) begin
      nxt_lineMode = MODE_CLOCKED;
    end else if (nxt_idleCnt >= ACT_LIMIT) begin
      nxt_lineMode = MODE_CLOCKLESS;
    end else begin
      nxt_lineMode = lineMode_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt_ff <= ACT_LIMIT;
      lineMode_ff <= MODE_CLOCKLESS;
    end else if (ce) begin
      idleCnt_ff <= nxt_idleCnt;
      lineMode_ff <= nxt_lineMode;
    end
  end

  // Mark capture: clock fall in clocked mode, rail rise otherwise
  always_comb begin
    if (lineMode_ff == MODE_CLOCKED) begin
      takePos = clockFall & posSync2_ff;
      takeNeg = clockFall & negSync2_ff;
    end else begin
      // One mark per RZ rise, held levels add nothing
      takePos = isRise(posPrev_ff, posSync2_ff);
      takeNeg = isRise(negPrev_ff, negSync2_ff);
    end
  end

  // Line state: positive wins if both rails arrive at once
  always_comb begin
    nxt_lineState = lineState_ff;
    nxt_markCnt = markCnt_ff;
    if (takePos) begin
      nxt_lineState = LINE_POS;
      nxt_markCnt = '0;
    end else if (takeNeg) begin
      nxt_lineState = LINE_NEG;
      nxt_markCnt = '0;
    end else begin
      unique case (lineState_ff)
        LINE_IDLE: begin
          nxt_markCnt = '0;
        end
        LINE_POS, LINE_NEG: begin
          if (markCnt_ff == MARK_LAST) begin
            nxt_lineState = LINE_IDLE;
            nxt_markCnt = '0;
          end else begin
            nxt_markCnt = markCnt_ff + MW'(1);
          end
        end
        default: begin
          nxt_lineState = LINE_IDLE;
          nxt_markCnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lineState_ff <= LINE_IDLE;
      markCnt_ff <= '0;
    end else if (ce) begin
      lineState_ff <= nxt_lineState;
      markCnt_ff <= nxt_markCnt;
    end
  end

  // Differential drive: A high for positive, B high for negative
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      driveA_ff <= 1'b0;
      driveB_ff <= 1'b0;
    end else if (ce) begin
      driveA_ff <= (nxt_lineState == LINE_POS);
      driveB_ff <= (nxt_lineState == LINE_NEG);
    end
  end

  // Flags a capture with both rails set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      railClash_ff <= 1'b0;
    end else if (ce) begin
      railClash_ff <= takePos & takeNeg;
    end
  end

  assign lineDriveOutA = driveA_ff;
  assign lineDriveOutB = driveB_ff;
  assign lineMode = lineMode_ff;
  assign railClash = railClash_ff;

endmodule

`default_nettype wire

// file: e1tx_asserts.sv
// Concurrent checks on the E1 transmit link and the device line outputs
`timescale 1ns/1ps
`default_nettype none

module e1tx_asserts #(
  parameter int ACT_CYC = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sendBitClock,
  input wire logic sendPositiveMark,
  input wire logic sendNegativeMark,
  input wire logic lineDriveOutA,
  input wire logic lineDriveOutB,
  input var e1tx_pkg::e1tx_mode_t lineMode,
  input wire logic railClash
);
  import e1tx_pkg::*;

  logic clkSeen_ff;
  logic [7:0] idleCnt_ff;

  // Cycles since the link clock last changed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkSeen_ff <= 1'h1;
      idleCnt_ff <= 8'h00;
    end else begin
      clkSeen_ff <= sendBitClock;
      if (sendBitClock != clkSeen_ff) begin
        idleCnt_ff <= 8'h00;
      end else if (idleCnt_ff != 8'hff) begin
        idleCnt_ff <= idleCnt_ff + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_pos_rz;
    $rose(sendPositiveMark) && !sendNegativeMark && lineMode == MODE_CLOCKLESS |-> ##[3:4] $rose(lineDriveOutA);
  endproperty
  a_pos_rz: assert property (p_pos_rz) else $error("positive mark not on line");

  property p_neg_rz;
    $rose(sendNegativeMark) && !sendPositiveMark && lineMode == MODE_CLOCKLESS |-> ##[3:4] $rose(lineDriveOutB);
  endproperty
  a_neg_rz: assert property (p_neg_rz) else $error("negative mark not on line");

  property p_fall_take;
    $fell(sendBitClock) && lineMode == MODE_CLOCKED && sendPositiveMark |-> ##[3:4] $rose(lineDriveOutA);
  endproperty
  a_fall_take: assert property (p_fall_take) else $error("clocked take missed");

  property p_width;
    $rose(lineDriveOutA || lineDriveOutB) |-> (lineDriveOutA || lineDriveOutB)[*5] ##1 !(lineDriveOutA || lineDriveOutB);
  endproperty
  a_width: assert property (p_width) else $error("line mark width wrong");

  property p_clash;
    !(sendPositiveMark && sendNegativeMark) && !railClash && !(lineDriveOutA && lineDriveOutB);
  endproperty
  a_clash: assert property (p_clash) else $error("both rails or both line outputs");

  property p_mode_on;
    $fell(sendBitClock) |-> ##[1:4] lineMode == MODE_CLOCKED;
  endproperty
  a_mode_on: assert property (p_mode_on) else $error("clock activity not seen");

  property p_mode_off;
    idleCnt_ff > ACT_CYC + 5 |-> lineMode == MODE_CLOCKLESS;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("clockless mode not resumed");

  property p_clk_low;
    $fell(sendBitClock) |-> !sendBitClock[*5] ##1 sendBitClock;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("bit clock low half wrong");

  property p_rz;
    $rose(sendPositiveMark) && $stable(sendBitClock) && sendBitClock |-> sendPositiveMark[*5] ##1 !sendPositiveMark;
  endproperty
  a_rz: assert property (p_rz) else $error("return to zero mark wrong");

  c_pos: cover property ($rose(lineDriveOutA));
  c_neg: cover property ($rose(lineDriveOutB));
  c_clocked: cover property ($rose(lineMode == MODE_CLOCKED));
endmodule

`default_nettype wire

// file: tb.sv
// Self-checking bench joining terminal and device ends of the E1 link
`timescale 1ns/1ps
`default_nettype none

module tb;
  import e1tx_pkg::*;

  logic clk, nrst, bitValid, bitPos, bitNeg, bitReady;
  logic lineA, lineB, clash, lineA2, lineB2, clash2;
  logic [1:0] lastLine = 2'h0;
  logic [1:0] r;
  logic [2:0] seen;
  logic [1:0] expq[$];
  e1tx_mode_t mode, lineMode, m;
  int n_errors = 0;
  int total_checks = 0;
  int i, j;
  logic ceOn;

  e1tx_if link();
  e1tx_if link2();

  e1tx_term e1tx_term_i (.clk(clk), .nrst(nrst), .ce(ceOn), .link(link), .sendMode(mode),
    .bitValid(bitValid), .bitPos(bitPos), .bitNeg(bitNeg), .bitReady(bitReady));
  e1tx_dev #(.ACT_NS(600)) e1tx_dev_i (.clk(clk), .nrst(nrst), .ce(ceOn), .link(link),
    .lineDriveOutA(lineA), .lineDriveOutB(lineB), .lineMode(lineMode), .railClash(clash));
  // Second device fed by the bench, which breaks the rail rule on purpose
  e1tx_dev #(.ACT_NS(600)) e1tx_dev_i2 (.clk(clk), .nrst(nrst), .ce(ceOn), .link(link2),
    .lineDriveOutA(lineA2), .lineDriveOutB(lineB2), .lineMode(), .railClash(clash2));
  e1tx_asserts #(.ACT_CYC(12)) e1tx_asserts_i (.clk(clk), .nrst(nrst),
    .sendBitClock(link.sendBitClock), .sendPositiveMark(link.sendPositiveMark),
    .sendNegativeMark(link.sendNegativeMark), .lineDriveOutA(lineA), .lineDriveOutB(lineB),
    .lineMode(lineMode), .railClash(clash));

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Offer one bit and wait for the terminal to take it
  task automatic send(input e1tx_mode_t sm, input logic p, input logic n);
    int k;
    @(negedge clk);
    mode = sm;
    bitValid = 1'h1;
    bitPos = p;
    bitNeg = n;
    for (k = 0; k < 12 && bitReady !== 1'h1; k++) @(negedge clk);
    check(bitReady, 1'h1);
    if (p) begin
      expq.push_back(2'h2);
    end else if (n) begin
      expq.push_back(2'h1);
    end
  endtask

  // Each new line mark is matched against the queue of offered marks
  always @(negedge clk) begin
    if (nrst && lastLine == 2'h0 && {lineA, lineB} != 2'h0) begin
      if (expq.size() == 0) begin
        check({lineA, lineB}, 2'h0);
      end else begin
        check({lineA, lineB}, expq.pop_front());
      end
    end
    lastLine = {lineA, lineB};
  end

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    nrst = 1'h0;
    ceOn = 1'h1;
    mode = MODE_CLOCKLESS;
    bitValid = 1'h0;
    bitPos = 1'h0;
    bitNeg = 1'h0;
    link2.sendBitClock = 1'h1;
    link2.sendPositiveMark = 1'h0;
    link2.sendNegativeMark = 1'h0;
    void'($urandom(16));
    repeat (10) @(negedge clk);
    nrst = 1'h1;
    check({lineA, lineB, clash}, 3'h0);
    check(lineMode, MODE_CLOCKLESS);
    for (i = 0; i < 4; i++) begin
      m = e1tx_mode_t'(i % 2);
      repeat (3) send(m, 1'h0, 1'h0);
      check(lineMode, m);
      for (j = 0; j < 30; j++) begin
        r = 2'($urandom);
        send(m, r[0], r[1]);
      end
    end
    // Stop offering, else the last bit is sent again
    @(negedge clk);
    bitValid = 1'h0;
    mode = MODE_CLOCKLESS;
    repeat (40) @(negedge clk);
    check(4'(expq.size()), 4'h0);
    // Frozen ends ignore rails raised while enable is low
    ceOn = 1'h0;
    link2.sendPositiveMark = 1'h1;
    link2.sendNegativeMark = 1'h1;
    repeat (6) @(negedge clk);
    check({lineA2, lineB2, clash2, lineMode}, 4'h0);
    ceOn = 1'h1;
    seen = 3'h0;
    for (i = 0; i < 10; i++) begin
      @(negedge clk);
      if (i == 4) begin
        link2.sendPositiveMark = 1'h0;
        link2.sendNegativeMark = 1'h0;
      end
      seen = seen | {lineA2, lineB2, clash2};
    end
    check(seen, 3'h5);
    summarize();
  end
endmodule

`default_nettype wire
